/* src/doc_output_cond.sv */
// The register addresses and register access over APB were chosen for this implementation.
module doc_output_cond
  import doc_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [15:0]        run_freq,
  input  wire logic [15:0]        set_freq,
  input  wire logic [15:0]        max_out_freq,
  input  wire logic [15:0]        out_current,
  input  wire logic [15:0]        rated_current,
  input  wire logic [15:0]        out_torque_abs,
  input  wire logic [15:0]        rated_torque,
  input  wire logic [15:0]        out_power,
  input  wire logic [15:0]        rated_power,
  input  wire logic [15:0]        out_voltage,
  input  wire logic [15:0]        rated_voltage,
  input  wire logic [15:0]        pulse_in_freq,
  input  wire logic [15:0]        analog_in_first,
  input  wire logic [15:0]        analog_in_second,
  input  wire logic [15:0]        analog_in_third,
  input  wire logic [15:0]        length_value,
  input  wire logic [15:0]        max_length,
  input  wire logic [15:0]        count_value,
  input  wire logic [15:0]        max_count,
  input  wire logic [15:0]        motor_speed,
  input  wire logic [15:0]        max_speed,
  input  wire logic signed [15:0] out_torque_signed,
  input  wire logic [4:0]         switch_status,
  input  wire logic               start_cmd,
  input  wire logic               stop_cmd,
  output logic                    pulse_freq_output,
  output logic      [13:0]        analog_out_first,
  output logic      [13:0]        analog_out_second,
  output logic      [4:0]         switch_to_common,
  output logic                    dc_brake_active,
  output logic                    pre_excite_active,
  output logic                    speed_tracking_active,
  output logic                    run_active
);
  logic [31:0]             func_sel_q;
  logic [15:0]             max_pf_q;
  logic signed [15:0]      ao_ofs_q  [2];
  logic signed [15:0]      ao_gain_q [2];
  logic [15:0]             dly_q     [5];
  logic [15:0]             pol_q;
  logic [1:0]              mode_cfg_q;
  logic [15:0]             brake_q;
  logic [15:0]             comm_q;
  logic [31:0]             rd_d;
  logic                    mapped;
  logic                    wr_en;
  logic [31:0]             tick_cnt_q;
  logic                    tick;
  logic [13:0]             x_pulse, x_ao1, x_ao2;
  logic [15:0]             pf_d, pf_q;
  logic [21:0]             acc_q;
  logic [4:0]              act_q;
  logic [15:0]             sw_cnt_q [5];
  logic [4:0]              neg;
  doc_state_t              state_q;
  doc_start_mode_t         mode_q;
  logic [15:0]             hold_cnt_q;
  logic                    start_take;

  // ---------------- register bus ----------------
  assign mapped  = (paddr[31:8] == 24'h0) && (paddr[1:0] == 2'h0) && (paddr[7:0] <= OFS_LAST);
  assign pready  = 1'b1;  // zero wait states keeps the host logic simple
  assign pslverr = psel && penable && !mapped;
  assign wr_en   = psel && penable && pwrite && mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_sel_q <= FUNC_SEL_RST;
      max_pf_q   <= MAX_PF_RST;
      pol_q      <= POL_RST;
      mode_cfg_q <= MODE_DIRECT;
      brake_q    <= BRAKE_RST;
      comm_q     <= COMM_RST;
      for (int i = 0; i < 2; i++) begin
        ao_ofs_q[i]  <= OFS_RST;
        ao_gain_q[i] <= GAIN_RST;
      end
      for (int i = 0; i < 5; i++) begin
        dly_q[i] <= DELAY_RST;
      end
    end else if (wr_en) begin
      case (paddr[7:0])
        OFS_FUNC_SEL: func_sel_q <= pwdata & 32'h001f_1f1f;
        OFS_MAX_PF:   max_pf_q   <= pwdata[15:0];
        OFS_AO1_OFS:  ao_ofs_q[0]  <= pwdata[15:0];
        OFS_AO1_GAIN: ao_gain_q[0] <= pwdata[15:0];
        OFS_AO2_OFS:  ao_ofs_q[1]  <= pwdata[15:0];
        OFS_AO2_GAIN: ao_gain_q[1] <= pwdata[15:0];
        OFS_POLARITY: pol_q      <= pwdata[15:0];
        OFS_START:    mode_cfg_q <= pwdata[1:0];
        OFS_BRAKE:    brake_q    <= pwdata[15:0];
        OFS_COMM:     comm_q     <= pwdata[15:0];
        default: begin
          for (int i = 0; i < 5; i++) begin
            if (paddr[7:0] == OFS_DELAY0 + 8'(4 * i)) begin
              dly_q[i] <= pwdata[15:0];
            end
          end
        end
      endcase
    end
  end

  always_comb begin
    rd_d = 32'h0;
    case (paddr[7:0])
      OFS_FUNC_SEL: rd_d = func_sel_q;
      OFS_MAX_PF:   rd_d = {16'h0, max_pf_q};
      OFS_AO1_OFS:  rd_d = {16'h0, ao_ofs_q[0]};
      OFS_AO1_GAIN: rd_d = {16'h0, ao_gain_q[0]};
      OFS_AO2_OFS:  rd_d = {16'h0, ao_ofs_q[1]};
      OFS_AO2_GAIN: rd_d = {16'h0, ao_gain_q[1]};
      OFS_POLARITY: rd_d = {16'h0, pol_q};
      OFS_START:    rd_d = {30'h0, mode_cfg_q};
      OFS_BRAKE:    rd_d = {16'h0, brake_q};
      OFS_COMM:     rd_d = {16'h0, comm_q};
      OFS_STATUS:   rd_d = {22'h0, state_q, 3'h0, switch_to_common};
      default: begin
        for (int i = 0; i < 5; i++) begin
          if (paddr[7:0] == OFS_DELAY0 + 8'(4 * i)) begin
            rd_d = {16'h0, dly_q[i]};
          end
        end
      end
    endcase
    if (!mapped) begin
      rd_d = 32'h0;
    end
  end

  // read data is caught in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_d;
    end
  end

  // ---------------- 0.1 s tick ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0;
    end else if (start_take || tick_cnt_q >= TICK_LEN - 1) begin
      tick_cnt_q <= 32'h0;  // restarted at start so braking never runs short
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end
  assign tick = (tick_cnt_q >= TICK_LEN - 1);

  // ---------------- quantity selection ----------------
  function automatic logic [13:0] std_out(input logic [4:0] code);
    logic signed [17:0] ts;
    ts = 18'(out_torque_signed) + 18'sh0 + $signed({1'b0, rated_torque, 1'b0});
    case (code)
      SEL_RUN_FREQ: return doc_scale({16'h0, run_freq}, {16'h0, max_out_freq});
      SEL_SET_FREQ: return doc_scale({16'h0, set_freq}, {16'h0, max_out_freq});
      SEL_CURRENT:  return doc_scale({16'h0, out_current}, {15'h0, rated_current, 1'b0});
      SEL_TORQUE:   return doc_scale({16'h0, out_torque_abs}, {15'h0, rated_torque, 1'b0});
      SEL_POWER:    return doc_scale({16'h0, out_power}, {15'h0, rated_power, 1'b0});
      SEL_VOLTAGE:  return doc_scale({13'h0, out_voltage, 3'h0} + {15'h0, out_voltage, 1'b0},
                                     {16'h0, rated_voltage} * 32'h0000_000c);
      SEL_PULSE_IN: return doc_scale({16'h0, pulse_in_freq}, FULL_W);
      SEL_AIN1:     return doc_scale({16'h0, analog_in_first}, FULL_W);
      SEL_AIN2:     return doc_scale({16'h0, analog_in_second}, FULL_W);
      SEL_AIN3:     return doc_scale({16'h0, analog_in_third}, FULL_W);
      SEL_LENGTH:   return doc_scale({16'h0, length_value}, {16'h0, max_length});
      SEL_COUNT:    return doc_scale({16'h0, count_value}, {16'h0, max_count});
      SEL_COMM:     return doc_scale({16'h0, comm_q}, 32'h0000_03e8);
      SEL_SPEED:    return doc_scale({16'h0, motor_speed}, {16'h0, max_speed});
      SEL_CURR_ABS: return doc_scale({16'h0, out_current}, FULL_W);
      SEL_VOLT_ABS: return doc_scale({16'h0, out_voltage}, FULL_W);
      SEL_TORQ_SGN: begin
        if (ts < 18'sh0) return 14'h0;
        return doc_scale({14'h0, ts}, {14'h0, rated_torque, 2'h0});
      end
      default:      return 14'h0;
    endcase
  endfunction

  // a process, not assign: std_out reads quantity ports beyond its argument
  always_comb begin
    x_pulse = std_out(func_sel_q[SEL_PULSE_LSB +: 5]);
    x_ao1   = std_out(func_sel_q[SEL_AO1_LSB +: 5]);
    x_ao2   = std_out(func_sel_q[SEL_AO2_LSB +: 5]);
  end

  // ---------------- analog outputs ----------------
  function automatic logic [13:0] ao_level(input logic [13:0] x, input logic signed [15:0] k,
                                           input logic signed [15:0] b);
    logic signed [33:0] kx;
    kx = 34'($signed({1'b0, x}) * k) / 34'sd100;
    return doc_clamp(kx + 34'(b) * 34'sd10);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_out_first  <= 14'h0;
      analog_out_second <= 14'h0;
    end else begin
      analog_out_first  <= ao_level(x_ao1, ao_gain_q[0], ao_ofs_q[0]);
      analog_out_second <= ao_level(x_ao2, ao_gain_q[1], ao_ofs_q[1]);
    end
  end

  // ---------------- pulse output ----------------
  always_comb begin
    pf_d = 16'(({16'h0, max_pf_q} * {18'h0, x_pulse}) / FULL_W);
    if (pf_d > max_pf_q) begin
      pf_d = max_pf_q;
    end
    if (pf_d == 16'h0) begin
      pf_d = 16'h1;
    end
  end

  // phase accumulator: one toggle per half period at pf_q x 10 Hz
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_q              <= 16'h1;
      acc_q             <= 22'h0;
      pulse_freq_output <= 1'b0;
    end else begin
      pf_q <= pf_d;
      if (acc_q + 22'(pf_q) >= PULSE_HALF_WRAP) begin
        acc_q             <= acc_q + 22'(pf_q) - PULSE_HALF_WRAP;
        pulse_freq_output <= !pulse_freq_output;
      end else begin
        acc_q <= acc_q + 22'(pf_q);
      end
    end
  end

  // ---------------- switched outputs ----------------
  always_comb begin
    logic [15:0] v;
    v = pol_q;
    for (int i = 0; i < 5; i++) begin
      neg[i] = ((v % 16'h000a) == 16'h0001);
      v      = v / 16'h000a;
    end
  end

  // a status that reverts before its delay ends restarts the wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= 5'h0;
      for (int i = 0; i < 5; i++) begin
        sw_cnt_q[i] <= 16'h0;
      end
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (switch_status[i] == act_q[i]) begin
          sw_cnt_q[i] <= 16'h0;
        end else if (dly_q[i] == 16'h0 || (tick && sw_cnt_q[i] + 16'h1 >= dly_q[i])) begin
          act_q[i]    <= switch_status[i];
          sw_cnt_q[i] <= 16'h0;
        end else if (tick) begin
          sw_cnt_q[i] <= sw_cnt_q[i] + 16'h1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_to_common <= 5'h0;
    end else begin
      switch_to_common <= act_q ^ neg;
    end
  end

  // ---------------- start sequencer ----------------
  assign start_take = start_cmd && !stop_cmd && state_q == ST_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ST_IDLE;
      mode_q     <= MODE_DIRECT;
      hold_cnt_q <= 16'h0;
    end else if (stop_cmd) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          hold_cnt_q <= 16'h0;
          if (start_cmd) begin
            // undefined mode 3 falls back to direct start
            mode_q <= (mode_cfg_q == 2'h3) ? MODE_DIRECT : doc_start_mode_t'(mode_cfg_q);
            if (mode_cfg_q == MODE_TRACK || brake_q == 16'h0) begin
              state_q <= ST_RUN;
            end else begin
              state_q <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          if (tick) begin
            if (hold_cnt_q + 16'h1 >= brake_q) begin
              state_q <= ST_RUN;
            end else begin
              hold_cnt_q <= hold_cnt_q + 16'h1;
            end
          end
        end
        ST_RUN:  state_q <= ST_RUN;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign dc_brake_active       = (state_q == ST_HOLD) && (mode_q == MODE_DIRECT);
  assign pre_excite_active     = (state_q == ST_HOLD) && (mode_q == MODE_PREEXC);
  assign speed_tracking_active = (state_q == ST_RUN) && (mode_q == MODE_TRACK);
  assign run_active            = (state_q == ST_RUN);

  // ---------------- checks ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_direct_run_now: assert property (
    start_take && mode_cfg_q == MODE_DIRECT && brake_q == 16'h0
      |=> run_active && !dc_brake_active)
    else $error("direct start without braking did not run at once");
  a_brake_first: assert property (
    start_take && mode_cfg_q == MODE_DIRECT && brake_q != 16'h0
      |=> dc_brake_active && !run_active)
    else $error("direct start with braking time skipped braking");
  a_brake_ends: assert property (
    dc_brake_active && tick && hold_cnt_q + 16'h1 >= brake_q && !stop_cmd
      |=> run_active)
    else $error("braking did not hand over to run");
  a_track_mode: assert property (
    start_take && mode_cfg_q == MODE_TRACK |=> speed_tracking_active)
    else $error("tracking start not entered");
  a_zero_delay: assert property (
    dly_q[0] == 16'h0 && switch_status[0] != act_q[0] |=> act_q[0] == $past(switch_status[0]))
    else $error("zero delay output did not follow status");
  a_delay_holds: assert property (
    dly_q[1] != 16'h0 && !tick && switch_status[1] != act_q[1] |=> $stable(act_q[1]))
    else $error("delayed output changed without a tick");
  a_pos_polarity: assert property (
    $stable(pol_q) && $stable(act_q) && !neg[0] |=> switch_to_common[0] == $past(act_q[0]))
    else $error("positive logic terminal wrong");
  a_neg_polarity: assert property (
    $stable(pol_q) && $stable(act_q) && neg[2] |=> switch_to_common[2] != $past(act_q[2]))
    else $error("negative logic terminal wrong");
  a_ao_unity: assert property (
    ao_gain_q[0] == GAIN_RST && ao_ofs_q[0] == 16'sh0 |=> analog_out_first == $past(x_ao1))
    else $error("unity gain output differs from standard output");
  a_ao_span: assert property (
    analog_out_first <= FULL && analog_out_second <= FULL)
    else $error("analog output beyond full scale");
  a_pulse_span: assert property (
    ##1 pf_q >= 16'h1 && (max_pf_q == 16'h0 || pf_q <= $past(max_pf_q, 2) || pf_q <= max_pf_q))
    else $error("pulse frequency outside span");
  a_bus_error: assert property (
    psel && penable && !mapped |-> pslverr)
    else $error("unmapped access without error");

  c_brake_then_run: cover property (dc_brake_active ##1 run_active);
  c_tracking_run:   cover property (speed_tracking_active);
  c_pulse_toggle:   cover property ($rose(pulse_freq_output));
  c_neg_terminal:   cover property (neg[4] && act_q[4] && !switch_to_common[4]);
endmodule

/* include/doc_pkg.sv */
package doc_pkg;
  localparam int unsigned CLK_NS          = 25;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned TICK_NS         = 100_000_000;  // 0.1 s setting unit
  localparam int unsigned TICK_CYCLES     = TICK_NS / CLK_NS;
  localparam int unsigned PULSE_UNIT_HZ   = 10;           // 0.01 kHz
  localparam logic [21:0] PULSE_HALF_WRAP = 22'(CLK_HZ / (2 * PULSE_UNIT_HZ));
  localparam logic [13:0] FULL            = 14'h2710;     // 100.00 % of span
  localparam logic [31:0] FULL_W          = 32'h0000_2710;

  localparam logic [7:0] OFS_FUNC_SEL  = 8'h00;
  localparam logic [7:0] OFS_MAX_PF    = 8'h04;
  localparam logic [7:0] OFS_AO1_OFS   = 8'h08;
  localparam logic [7:0] OFS_AO1_GAIN  = 8'h0c;
  localparam logic [7:0] OFS_AO2_OFS   = 8'h10;
  localparam logic [7:0] OFS_AO2_GAIN  = 8'h14;
  localparam logic [7:0] OFS_DELAY0    = 8'h18;  // five words up to 8'h28
  localparam logic [7:0] OFS_POLARITY  = 8'h2c;
  localparam logic [7:0] OFS_START     = 8'h30;
  localparam logic [7:0] OFS_BRAKE     = 8'h34;
  localparam logic [7:0] OFS_COMM      = 8'h38;
  localparam logic [7:0] OFS_STATUS    = 8'h3c;
  localparam logic [7:0] OFS_LAST      = 8'h3c;

  localparam int unsigned SEL_PULSE_LSB = 0;
  localparam int unsigned SEL_AO1_LSB   = 8;
  localparam int unsigned SEL_AO2_LSB   = 16;
  localparam int unsigned STAT_STATE_LSB = 8;

  localparam logic [31:0] FUNC_SEL_RST = 32'h0001_0000;  // pulse 0, first 0, second 1
  localparam logic [15:0] MAX_PF_RST   = 16'h1388;       // 5000 x 0.01 kHz
  localparam logic [15:0] GAIN_RST     = 16'h0064;       // 1.00
  localparam logic [15:0] OFS_RST      = 16'h0000;
  localparam logic [15:0] DELAY_RST    = 16'h0000;
  localparam logic [15:0] POL_RST      = 16'h0000;
  localparam logic [15:0] BRAKE_RST    = 16'h0000;
  localparam logic [15:0] COMM_RST     = 16'h0000;

  typedef enum logic [4:0] {
    SEL_RUN_FREQ = 5'h00, SEL_SET_FREQ = 5'h01, SEL_CURRENT  = 5'h02,
    SEL_TORQUE   = 5'h03, SEL_POWER    = 5'h04, SEL_VOLTAGE  = 5'h05,
    SEL_PULSE_IN = 5'h06, SEL_AIN1     = 5'h07, SEL_AIN2     = 5'h08,
    SEL_AIN3     = 5'h09, SEL_LENGTH   = 5'h0a, SEL_COUNT    = 5'h0b,
    SEL_COMM     = 5'h0c, SEL_SPEED    = 5'h0d, SEL_CURR_ABS = 5'h0e,
    SEL_VOLT_ABS = 5'h0f, SEL_TORQ_SGN = 5'h10
  } doc_sel_t;

  typedef enum logic [1:0] {
    MODE_DIRECT = 2'h0, MODE_TRACK = 2'h1, MODE_PREEXC = 2'h2
  } doc_start_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_HOLD = 2'b01, ST_RUN = 2'b11
  } doc_state_t;

  // fraction num/den of full span, clamped to full span
  function automatic logic [13:0] doc_scale(input logic [31:0] num, input logic [31:0] den);
    logic [63:0] q;
    q = 64'h0;
    if (den == 32'h0) return 14'h0;
    q = ({32'h0, num} * {32'h0, FULL_W}) / {32'h0, den};
    if (q > {50'h0, FULL}) return FULL;
    return q[13:0];
  endfunction

  function automatic logic [13:0] doc_clamp(input logic signed [33:0] v);
    if (v < 34'sh0) return 14'h0;
    if (v > $signed({20'h0, FULL})) return FULL;
    return v[13:0];
  endfunction
endpackage

/* testbench/doc_load_wiring.sv */
module doc_load_wiring (
  input  wire logic [4:0] switch_to_common,
  output logic      [4:0] term_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // terminals are pulled up: a released switch reads high, never the last value
  assign term_level = ~switch_to_common;
endmodule

/* testbench/doc_output_cond_test.sv */
module doc_output_cond_test import doc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [15:0] qv [22];
  logic [4:0]  sw_stat, to_com, lvl;
  logic        start_cmd, stop_cmd, pulse_o, brk, pre, trk, run;
  logic [13:0] ao1, ao2;
  logic [32:0] exp_q [$];
  logic [32:0] note, e;
  logic        p_prev;
  int          num_errors, checked, seed, i;

  doc_output_cond #(.TICK_LEN(4)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .run_freq(qv[0]), .set_freq(qv[1]), .max_out_freq(qv[2]), .out_current(qv[3]),
    .rated_current(qv[4]), .out_torque_abs(qv[5]), .rated_torque(qv[6]),
    .out_power(qv[7]), .rated_power(qv[8]), .out_voltage(qv[9]), .rated_voltage(qv[10]),
    .pulse_in_freq(qv[11]), .analog_in_first(qv[12]), .analog_in_second(qv[13]),
    .analog_in_third(qv[14]), .length_value(qv[15]), .max_length(qv[16]),
    .count_value(qv[17]), .max_count(qv[18]), .motor_speed(qv[19]), .max_speed(qv[20]),
    .out_torque_signed(qv[21]), .switch_status(sw_stat), .start_cmd(start_cmd),
    .stop_cmd(stop_cmd), .pulse_freq_output(pulse_o), .analog_out_first(ao1),
    .analog_out_second(ao2), .switch_to_common(to_com), .dc_brake_active(brk),
    .pre_excite_active(pre), .speed_tracking_active(trk), .run_active(run));

  doc_load_wiring i_load (.switch_to_common(to_com), .term_level(lvl));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [32:0] ex, input logic [32:0] got);
    checked++;
    if (got !== ex) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, ex, got);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // setup on one edge, access on the next, hold until pready is seen high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic err);
    exp_q.push_back({err, d});
    apb(1'b0, a, 32'h0);
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) chk("read note", 33'h0, 33'h1);
      else begin
        note = exp_q.pop_front();
        chk("prdata", note, {pslverr, prdata});
      end
    end
  end

  task automatic pulse_start(input logic s);
    @(posedge pclk);
    start_cmd <= s; stop_cmd <= !s;
    @(posedge pclk);
    start_cmd <= 1'b0; stop_cmd <= 1'b0;
    wt(1);
  endtask

  initial begin
    seed = 32'h0c2a;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0; pwdata = 32'h0; sw_stat = 5'h0; start_cmd = 1'b0; stop_cmd = 1'b0;
    foreach (qv[k]) qv[k] = 16'($unsigned($random(seed)) % (FULL + 1));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(32'h00, 32'h0001_0000, 1'b0);
    rd(32'h04, 32'h0000_1388, 1'b0);
    rd(32'h0c, 32'h0000_0064, 1'b0);
    rd(32'h2c, 32'h0000_0000, 1'b0);
    rd(32'h40, 32'h0000_0000, 1'b1);
    $display("register defaults done");
    // each code but 7 and 8 (analog inputs 1 and 2), 14 and 15 (absolute current, voltage) sees half its span, so those others land on 5000
    qv[0] <= 2500; qv[1] <= 2500; qv[2] <= 5000; qv[3] <= 1000; qv[4] <= 1000;
    qv[5] <= 1000; qv[6] <= 1000; qv[7] <= 1000; qv[8] <= 1000; qv[9] <= 600;
    qv[10] <= 1000; qv[11] <= 5000; qv[14] <= 5000; qv[15] <= 500; qv[16] <= 1000;
    qv[17] <= 50; qv[18] <= 100; qv[19] <= 300; qv[20] <= 600; qv[21] <= 0;
    apb(1'b1, 32'(OFS_COMM), 32'd500);
    for (i = 0; i < 17; i++) begin
      apb(1'b1, 32'(OFS_FUNC_SEL), 32'(i) << 8);
      wt(3);
      e = (i == 14) ? 1000 : (i == 15) ? 600 : (i == 7) ? qv[12] : (i == 8) ? qv[13] : 5000;
      chk("ao1 span", e, 33'(ao1));
      chk("ao2 span", 33'd5000, 33'(ao2));
    end
    $display("selector codes done");
    apb(1'b1, 32'(OFS_FUNC_SEL), 32'h0);
    apb(1'b1, 32'(OFS_AO1_GAIN), 32'h0000_ffce);
    apb(1'b1, 32'(OFS_AO1_OFS), 32'h0000_0320);
    qv[0] <= 16'h0;
    wt(3);
    chk("ao1 offset", 33'd8000, 33'(ao1));
    qv[0] <= 16'd5000;
    wt(3);
    chk("ao1 gain", 33'd3000, 33'(ao1));
    apb(1'b1, 32'(OFS_AO1_OFS), 32'h0000_fc18);
    wt(3);
    chk("ao1 low clamp", 33'd0, 33'(ao1));
    apb(1'b1, 32'(OFS_AO1_OFS), 32'h0);
    apb(1'b1, 32'(OFS_AO1_GAIN), 32'h0000_03e8);
    wt(3);
    chk("ao1 high clamp", 33'(FULL), 33'(ao1));
    $display("gain offset done");
    apb(1'b1, 32'(OFS_POLARITY), 32'd10);
    wt(3);
    chk("terminal level", 33'h1d, 33'(lvl));
    sw_stat <= 5'h03;
    wt(1);
    chk("switch early", 33'h02, 33'(to_com));
    wt(1);
    chk("switch follow", 33'h01, 33'(to_com));
    apb(1'b1, 32'(OFS_DELAY0), 32'd2);
    sw_stat <= 5'h02;
    wt(3);
    chk("delayed hold", 33'h01, 33'(to_com));
    wt(14);
    chk("delayed change", 33'h00, 33'(to_com));
    $display("switched outputs done");
    pulse_start(1'b1);
    chk("direct run", 33'h1, 33'({brk, run}));
    pulse_start(1'b0);
    apb(1'b1, 32'(OFS_BRAKE), 32'd1);
    for (i = 0; i < 3; i++) begin
      apb(1'b1, 32'(OFS_START), 32'(i));
      pulse_start(1'b1);
      e = 33'({i == 0, i == 2, i == 1, i == 1});
      chk("start flags", e, 33'({brk, pre, trk, run}));
      wt(4);
      chk("start run", 33'({i == 1, 1'b1}), 33'({brk, pre, trk, run}));
      rd(32'(OFS_STATUS), 32'h0000_0300, 1'b0);
      pulse_start(1'b0);
      chk("stopped", 33'h0, 33'(run));
    end
    $display("start modes done");
    // full input at 100.00 kHz: one toggle every 200 cycles, 5 in 1000
    apb(1'b1, 32'(OFS_MAX_PF), 32'd10000);
    wt(3);
    p_prev = pulse_o;
    e = 33'h0;
    repeat (1000) begin
      wt(1);
      if (pulse_o !== p_prev) e = e + 33'h1;
      p_prev = pulse_o;
    end
    chk("pulse toggles", 33'd5, e);
    $display("pulse output done");
    give_verdict();
  end
endmodule
